//--- rtl/acg_pkg.sv
// acg_pkg: constants for the audio clock generator power and lock block
// Function
// - Lowest bit of lock status register reads 1 when generator three is locked.
// - Lock follows the selected reference: PLL output or external, chosen by bit 4.
// - Lock status register reads all zeros after reset.
// - A power-enable register holds enable bits for generators two and three.
// - Power-enable register resets to zero, so every gated unit starts disabled.
// - Bit 12 low disables generator three; high powers it.
// - Blocks clocked from generator three stop while bit 12 is low.
// - Bit 11 low disables generator two; high powers it.
// - Clock pins sourced from generator two drive low while it is disabled.
// - Blocks clocked from generator two stop while bit 11 is low.
package acg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned ADR_W = 18;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned SEL_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_GEN3_CFG  = 16'hF026;
    localparam logic [15:0] IDX_GEN_THREE_LOCKED_FLAG = 16'hF027;
    localparam logic [15:0] IDX_POWER_A   = 16'hF050;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned BIT_GEN3_LOCKED = 0;
    localparam int unsigned BIT_GEN3_REFSEL = 4;
    localparam int unsigned BIT_GEN2_PWR    = 11;
    localparam int unsigned BIT_GEN3_PWR    = 12;

    ////////////////////////////////////////////////////////////////////////////
    // reset values of the registers and the bus data
    localparam logic [15:0] RST_GEN3_CFG  = 16'h0000;
    localparam logic [15:0] RST_GEN_THREE_LOCKED_FLAG = 16'h0000;
    localparam logic [15:0] RST_POWER_A   = 16'h0000;
    localparam logic [31:0] RST_DATA      = 32'h00000000;

endpackage : acg_pkg

//--- rtl/acg_pin_gate.sv
// acg_pin_gate: forces generator-sourced clock pins low while that generator is off
`timescale 1ns/1ns
`default_nettype none
module acg_pin_gate #(
    parameter int unsigned N = 4
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic         genOn,
    input  wire logic [N-1:0] srcIsGen,
    input  wire logic [N-1:0] rawClk,
    output var  logic [N-1:0] pinOut
);

    logic [N-1:0] pinReg;
    logic [N-1:0] pinNext;

    ////////////////////////////////////////////////////////////////////////////
    // one register stage keeps the pin glitch free when the source flips
    always_comb begin
        pinNext = rawClk & ~(srcIsGen & {N{~genOn}});
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pinReg <= '0;
        end else begin
            pinReg <= pinNext;
        end
    end

    assign pinOut = pinReg;

    ////////////////////////////////////////////////////////////////////////////
    chk_pin_low_off: assert property (@(posedge mclk) disable iff (!nrst)
        ((pinReg & $past(srcIsGen) & {N{~$past(genOn)}}) == '0))
        else $error("gated clock pin not low while generator off");

    chk_pin_pass_on: assert property (@(posedge mclk) disable iff (!nrst)
        $past(genOn) |-> (pinReg == $past(rawClk)))
        else $error("clock pin does not follow source while generator on");

endmodule : acg_pin_gate
`default_nettype wire

//--- rtl/acg_clock_power.sv
// acg_clock_power: wishbone register slave gating generators two and three
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`default_nettype none
module acg_clock_power
    import acg_pkg::*;
#(
    parameter int unsigned NUM_PINS   = 4,
    parameter int unsigned NUM_BLOCKS = 8
) (
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    input  wire logic                    wbCyc,
    input  wire logic                    wbStb,
    input  wire logic                    wbWe,
    input  wire logic [acg_pkg::ADR_W-1:0] wbAdr,
    input  wire logic [acg_pkg::SEL_W-1:0] wbSel,
    input  wire logic [acg_pkg::DAT_W-1:0] wbDatI,
    output var  logic [acg_pkg::DAT_W-1:0] wbDatO,
    output var  logic                    wbAck,
    input  wire logic                    pllRefLocked,
    input  wire logic                    extRefLocked,
    output var  logic                    genThreeRefSelect,
    output var  logic                    genThreeLockedFlag,
    output var  logic                    genThreePowerOn,
    output var  logic                    genTwoPowerOn,
    input  wire logic                    coreUsesGenThree,
    input  wire logic                    coreUsesGenTwo,
    output var  logic                    coreRunEnable,
    input  wire logic [NUM_BLOCKS-1:0]   blockUsesGenThree,
    input  wire logic [NUM_BLOCKS-1:0]   blockUsesGenTwo,
    output var  logic [NUM_BLOCKS-1:0]   blockRunEnable,
    input  wire logic [NUM_PINS-1:0]     frameOutSrcGenTwo,
    input  wire logic [NUM_PINS-1:0]     frameOutRaw,
    output var  logic [NUM_PINS-1:0]     frameClockOutPin,
    input  wire logic [NUM_PINS-1:0]     frameInSrcGenTwo,
    input  wire logic [NUM_PINS-1:0]     frameInRaw,
    output var  logic [NUM_PINS-1:0]     frameClockInPin,
    input  wire logic [NUM_PINS-1:0]     bitOutSrcGenTwo,
    input  wire logic [NUM_PINS-1:0]     bitOutRaw,
    output var  logic [NUM_PINS-1:0]     bitClockOutPin,
    input  wire logic [NUM_PINS-1:0]     bitInSrcGenTwo,
    input  wire logic [NUM_PINS-1:0]     bitInRaw,
    output var  logic [NUM_PINS-1:0]     bitClockInPin
);

    import acg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave state
    logic                 ackReg;
    logic                 ackNext;
    logic [DAT_W-1:0]     datReg;
    logic [DAT_W-1:0]     datNext;
    logic                 request;
    logic                 commit;
    logic                 hitCfg;
    logic                 hitLock;
    logic                 hitPower;
    logic [15:0]          wordIdx;

    // register state
    logic                 refSelReg;
    logic                 refSelNext;
    logic                 gen3PwrReg;
    logic                 gen3PwrNext;
    logic                 gen2PwrReg;
    logic                 gen2PwrNext;
    logic                 lockedReg;
    logic                 lockedNext;

    // run-enable state
    logic                 coreRunReg;
    logic                 coreRunNext;
    logic [NUM_BLOCKS-1:0] blockRunReg;
    logic [NUM_BLOCKS-1:0] blockRunNext;

    // readback images
    logic [REG_W-1:0]     cfgImage;
    logic [REG_W-1:0]     lockImage;
    logic [REG_W-1:0]     powerImage;

    ////////////////////////////////////////////////////////////////////////////
    // address decode; low two byte-address bits are ignored
    assign wordIdx  = wbAdr[17:2];
    assign hitCfg   = (wordIdx == IDX_GEN3_CFG);
    assign hitLock  = (wordIdx == IDX_GEN_THREE_LOCKED_FLAG);
    assign hitPower = (wordIdx == IDX_POWER_A);
    assign request  = wbCyc & wbStb & ~ackReg;
    assign commit   = wbCyc & wbStb & ackReg;

    ////////////////////////////////////////////////////////////////////////////
    // readback: unimplemented and reserved bits read zero
    always_comb begin
        cfgImage   = RST_GEN3_CFG;
        cfgImage[BIT_GEN3_REFSEL] = refSelReg;
        lockImage  = RST_GEN_THREE_LOCKED_FLAG;
        lockImage[BIT_GEN3_LOCKED] = lockedReg;
        powerImage = RST_POWER_A;
        powerImage[BIT_GEN3_PWR] = gen3PwrReg;
        powerImage[BIT_GEN2_PWR] = gen2PwrReg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone answer: ack one cycle after the request, data sampled then
    always_comb begin
        ackNext = request;
        datNext = datReg;
        if (request) begin
            datNext = RST_DATA;
            if (!wbWe) begin
                if (hitCfg) begin
                    datNext[REG_W-1:0] = cfgImage;
                end else if (hitLock) begin
                    datNext[REG_W-1:0] = lockImage;
                end else if (hitPower) begin
                    datNext[REG_W-1:0] = powerImage;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ackReg <= 1'b0;
            datReg <= RST_DATA;
        end else begin
            ackReg <= ackNext;
            datReg <= datNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // writes land on the edge where the master sees ack; lock bit ignores data
    always_comb begin
        refSelNext  = refSelReg;
        gen3PwrNext = gen3PwrReg;
        gen2PwrNext = gen2PwrReg;
        if (commit && wbWe) begin
            if (hitCfg && wbSel[0]) begin
                refSelNext = wbDatI[BIT_GEN3_REFSEL];
            end
            if (hitPower && wbSel[1]) begin
                gen3PwrNext = wbDatI[BIT_GEN3_PWR];
                gen2PwrNext = wbDatI[BIT_GEN2_PWR];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            refSelReg  <= RST_GEN3_CFG[BIT_GEN3_REFSEL];
            gen3PwrReg <= RST_POWER_A[BIT_GEN3_PWR];
            gen2PwrReg <= RST_POWER_A[BIT_GEN2_PWR];
        end else begin
            refSelReg  <= refSelNext;
            gen3PwrReg <= gen3PwrNext;
            gen2PwrReg <= gen2PwrNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lock status; a powered-down generator never claims lock
    always_comb begin
        lockedNext = gen3PwrReg & (refSelReg ? extRefLocked : pllRefLocked);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lockedReg <= RST_GEN_THREE_LOCKED_FLAG[BIT_GEN3_LOCKED];
        end else begin
            lockedReg <= lockedNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run enables; a block follows its generator one cycle after the write
    always_comb begin
        coreRunNext  = ~(coreUsesGenThree & ~gen3PwrReg) & ~(coreUsesGenTwo & ~gen2PwrReg);
        blockRunNext = ~(blockUsesGenThree & {NUM_BLOCKS{~gen3PwrReg}})
                     & ~(blockUsesGenTwo & {NUM_BLOCKS{~gen2PwrReg}});
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            coreRunReg  <= 1'b0;
            blockRunReg <= '0;
        end else begin
            coreRunReg  <= coreRunNext;
            blockRunReg <= blockRunNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock pins driven from generator two
    acg_pin_gate #(.N(NUM_PINS)) uFrameOut (
        .mclk     (mclk),
        .nrst     (nrst),
        .genOn    (gen2PwrReg),
        .srcIsGen (frameOutSrcGenTwo),
        .rawClk   (frameOutRaw),
        .pinOut   (frameClockOutPin)
    );

    acg_pin_gate #(.N(NUM_PINS)) uFrameIn (
        .mclk     (mclk),
        .nrst     (nrst),
        .genOn    (gen2PwrReg),
        .srcIsGen (frameInSrcGenTwo),
        .rawClk   (frameInRaw),
        .pinOut   (frameClockInPin)
    );

    acg_pin_gate #(.N(NUM_PINS)) uBitOut (
        .mclk     (mclk),
        .nrst     (nrst),
        .genOn    (gen2PwrReg),
        .srcIsGen (bitOutSrcGenTwo),
        .rawClk   (bitOutRaw),
        .pinOut   (bitClockOutPin)
    );

    acg_pin_gate #(.N(NUM_PINS)) uBitIn (
        .mclk     (mclk),
        .nrst     (nrst),
        .genOn    (gen2PwrReg),
        .srcIsGen (bitInSrcGenTwo),
        .rawClk   (bitInRaw),
        .pinOut   (bitClockInPin)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign wbAck              = ackReg;
    assign wbDatO             = datReg;
    assign genThreeRefSelect  = refSelReg;
    assign genThreeLockedFlag = lockedReg;
    assign genThreePowerOn    = gen3PwrReg;
    assign genTwoPowerOn      = gen2PwrReg;
    assign coreRunEnable      = coreRunReg;
    assign blockRunEnable     = blockRunReg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cbMain @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    chk_bus_ack_timing: assert property (request |=> ackReg ##1 !ackReg)
        else $error("ack not a single pulse one cycle after request");

    chk_lock_read_value: assert property ((request && !wbWe && hitLock) |=>
        (datReg == {16'h0000, 15'h0000, $past(lockedReg)}))
        else $error("lock register readback wrong");

    chk_lock_ext_ref: assert property ((gen3PwrReg && refSelReg) |=>
        (lockedReg == $past(extRefLocked)))
        else $error("lock does not follow external reference");

    chk_lock_pll_ref: assert property ((gen3PwrReg && !refSelReg) |=>
        (lockedReg == $past(pllRefLocked)))
        else $error("lock does not follow pll reference");

    chk_lock_gen_off: assert property (!gen3PwrReg |=> !lockedReg)
        else $error("generator three reported locked while off");

    chk_power_write_lands: assert property ((commit && wbWe && hitPower && wbSel[1]) |=>
        (gen3PwrReg == $past(wbDatI[12])) && (gen2PwrReg == $past(wbDatI[11])))
        else $error("power enable write not taken");

    chk_power_holds_idle: assert property (!(commit && wbWe && hitPower) |=> $stable(gen3PwrReg) && $stable(gen2PwrReg))
        else $error("power enable changed without a write");

    chk_gen3_blocks_stop: assert property (!gen3PwrReg |=>
        ((blockRunReg & $past(blockUsesGenThree)) == '0) && !(coreRunReg && $past(coreUsesGenThree)))
        else $error("block on generator three runs while it is off");

    chk_gen2_blocks_stop: assert property (!gen2PwrReg |=>
        ((blockRunReg & $past(blockUsesGenTwo)) == '0) && !(coreRunReg && $past(coreUsesGenTwo)))
        else $error("block on generator two runs while it is off");

    chk_power_read_image: assert property ((request && !wbWe && hitPower) |=>
        (datReg == {16'h0000, 3'b000, $past(gen3PwrReg), $past(gen2PwrReg), 11'h000}))
        else $error("power register readback wrong");

    chk_unmapped_zero: assert property ((request && !wbWe && !hitCfg && !hitLock && !hitPower) |=>
        (datReg == RST_DATA))
        else $error("unmapped read not zero");

    chk_cfg_write_lands: assert property ((commit && wbWe && hitCfg && wbSel[0]) |=>
        (refSelReg == $past(wbDatI[BIT_GEN3_REFSEL])))
        else $error("reference select write not taken");

    chk_units_run_on: assert property ((gen3PwrReg && gen2PwrReg) |=>
        (blockRunReg == '1) && coreRunReg)
        else $error("block stopped while both generators on");

    cov_gen3_power_on: cover property (commit && wbWe && hitPower && wbSel[1] && wbDatI[12]);
    cov_lock_gained: cover property ($rose(lockedReg));
    cov_lock_read: cover property (request && !wbWe && hitLock ##1 ackReg && datReg[0]);
    cov_gen2_gated: cover property ($fell(gen2PwrReg) ##1 !coreRunReg);
    cov_ext_ref_chosen: cover property (commit && wbWe && hitCfg && wbSel[0] && wbDatI[BIT_GEN3_REFSEL]);

endmodule : acg_clock_power
`default_nettype wire

//--- testbench/acg_clock_power_tb.sv
// acg_clock_power_tb: register and gating tests for the clock power block
`timescale 1ns/1ns
`default_nettype none
module acg_clock_power_tb;
    import acg_pkg::*;
    localparam logic [ADR_W-1:0] ADR_CFG  = {IDX_GEN3_CFG, 2'b00};
    localparam logic [ADR_W-1:0] ADR_LOCK = {IDX_GEN_THREE_LOCKED_FLAG, 2'b00};
    localparam logic [ADR_W-1:0] ADR_PWR  = {IDX_POWER_A, 2'b00};
    localparam logic [ADR_W-1:0] ADR_NONE = 18'h3C100;

    logic             mclk, nrst, wbCyc, wbStb, wbWe, wbAck;
    logic [ADR_W-1:0] wbAdr;
    logic [SEL_W-1:0] wbSel;
    logic [DAT_W-1:0] wbDatI, wbDatO, rd;
    logic             pllRefLocked, extRefLocked, genThreeRefSelect, genThreeLockedFlag;
    logic             genThreePowerOn, genTwoPowerOn, coreUsesGenThree, coreUsesGenTwo, coreRunEnable;
    logic [7:0]       blockUsesGenThree, blockUsesGenTwo, blockRunEnable;
    logic [3:0]       foSrc, foRaw, foPin, fiSrc, fiRaw, fiPin, boSrc, boRaw, boPin, biSrc, biRaw, biPin;
    int               failures, tests_run;

    acg_clock_power dut (.mclk(mclk), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
        .pllRefLocked(pllRefLocked), .extRefLocked(extRefLocked), .genThreeRefSelect(genThreeRefSelect),
        .genThreeLockedFlag(genThreeLockedFlag), .genThreePowerOn(genThreePowerOn),
        .genTwoPowerOn(genTwoPowerOn), .coreUsesGenThree(coreUsesGenThree), .coreUsesGenTwo(coreUsesGenTwo),
        .coreRunEnable(coreRunEnable), .blockUsesGenThree(blockUsesGenThree),
        .blockUsesGenTwo(blockUsesGenTwo), .blockRunEnable(blockRunEnable),
        .frameOutSrcGenTwo(foSrc), .frameOutRaw(foRaw), .frameClockOutPin(foPin),
        .frameInSrcGenTwo(fiSrc), .frameInRaw(fiRaw), .frameClockInPin(fiPin),
        .bitOutSrcGenTwo(boSrc), .bitOutRaw(boRaw), .bitClockOutPin(boPin),
        .bitInSrcGenTwo(biSrc), .bitInRaw(biRaw), .bitClockInPin(biPin));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic check_reg(input string what, input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_reg

    task automatic check_sig(input string what, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_sig

    // one classic cycle; request held until ack is sampled high
    task automatic wb_cycle(input logic we, input logic [ADR_W-1:0] adr, input logic [SEL_W-1:0] sel,
                            input logic [DAT_W-1:0] dat, output logic [DAT_W-1:0] data);
        int n;
        n = 0;
        @(posedge mclk);
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= adr; wbSel <= sel; wbDatI <= dat;
        do begin
            @(posedge mclk);
            n++;
        end while (wbAck !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            $display("wrong value at %0t: no bus answer", $time);
        end
        data = wbDatO;
        wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
    endtask : wb_cycle

    task automatic wb_write(input logic [ADR_W-1:0] adr, input logic [SEL_W-1:0] sel, input logic [15:0] dat);
        logic [DAT_W-1:0] dummy;
        wb_cycle(1'b1, adr, sel, {16'h0000, dat}, dummy);
    endtask : wb_write

    task automatic wb_read(input logic [ADR_W-1:0] adr, output logic [DAT_W-1:0] data);
        wb_cycle(1'b0, adr, 4'hF, 32'h00000000, data);
    endtask : wb_read

    // let the register update ripple to the gated outputs, sample mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    task automatic check_gating(input logic pw3, input logic pw2);
        check_sig("gen3 power", genThreePowerOn, pw3);
        check_sig("gen2 power", genTwoPowerOn, pw2);
        check_sig("core run", coreRunEnable, !(coreUsesGenThree && !pw3) && !(coreUsesGenTwo && !pw2));
        check_sig("block run", blockRunEnable, ~((blockUsesGenThree & {8{~pw3}}) | (blockUsesGenTwo & {8{~pw2}})));
        check_sig("frame out", foPin, foRaw & ~(foSrc & {4{~pw2}}));
        check_sig("frame in", fiPin, fiRaw & ~(fiSrc & {4{~pw2}}));
        check_sig("bit out", boPin, boRaw & ~(boSrc & {4{~pw2}}));
        check_sig("bit in", biPin, biRaw & ~(biSrc & {4{~pw2}}));
        check_sig("lock flag", genThreeLockedFlag, pw3 & extRefLocked);
    endtask : check_gating

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0; tests_run = 0; nrst = 1'b0;
        wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; wbAdr = '0; wbSel = '0; wbDatI = '0;
        pllRefLocked = 1'b1; extRefLocked = 1'b0; coreUsesGenThree = 1'b1; coreUsesGenTwo = 1'b1;
        blockUsesGenThree = 8'h0F; blockUsesGenTwo = 8'hF0;
        foSrc = 4'h5; fiSrc = 4'hA; boSrc = 4'h3; biSrc = 4'hC;
        foRaw = 4'hF; fiRaw = 4'hB; boRaw = 4'hE; biRaw = 4'h7;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        // reset state; pll locked yet gen3 unpowered
        wb_read(ADR_LOCK, rd); check_reg("lock reset", rd, 32'h00000000);
        wb_read(ADR_PWR, rd); check_reg("power reset", rd, 32'h00000000);
        wb_read(ADR_CFG, rd); check_reg("cfg reset", rd, 32'h00000000);
        settle(0); check_gating(1'b0, 1'b0);
        // reserved bits discarded, enables stick
        wb_write(ADR_PWR, 4'h3, 16'hFFFF);
        wb_read(ADR_PWR, rd); check_reg("power rw", rd, 32'h00001800);
        // every reference choice against every lock input
        for (int k = 0; k < 8; k++) begin
            wb_write(ADR_CFG, 4'h1, {11'h000, k[2], 4'h0});
            pllRefLocked <= k[1]; extRefLocked <= k[0];
            settle(2);
            check_sig("ref select", genThreeRefSelect, k[2]);
            check_sig("lock flag", genThreeLockedFlag, k[2] ? k[0] : k[1]);
            wb_read(ADR_LOCK, rd); check_reg("lock reg", rd, {31'h0, (k[2] ? k[0] : k[1])});
        end
        // lock bit is read-only
        wb_write(ADR_LOCK, 4'hF, 16'h0000);
        wb_read(ADR_LOCK, rd); check_reg("lock ro", rd, 32'h00000001);
        // each power combination with a fresh routing pattern
        for (int i = 0; i < 4; i++) begin
            blockUsesGenThree <= 8'h33 << i; blockUsesGenTwo <= 8'hF0 >> i;
            coreUsesGenThree <= ~i[1]; coreUsesGenTwo <= i[1] | ~i[0];
            foSrc <= 4'h5 ^ i[3:0]; fiSrc <= 4'hA ^ i[3:0]; boSrc <= 4'hF; biSrc <= 4'h6;
            foRaw <= 4'hF - i[3:0]; fiRaw <= 4'hB; boRaw <= 4'hE ^ i[3:0]; biRaw <= 4'hF;
            wb_write(ADR_PWR, 4'h3, {3'b000, i[1], i[0], 11'h000});
            settle(2);
            check_gating(i[1], i[0]);
            wb_read(ADR_LOCK, rd); check_reg("lock vs power", rd, {31'h0, i[1]});
        end
        // lane 1 disabled: enables untouched
        wb_write(ADR_PWR, 4'hD, 16'h0000);
        wb_read(ADR_PWR, rd); check_reg("power lanes", rd, 32'h00001800);
        // unmapped place reads zero
        wb_write(ADR_NONE, 4'hF, 16'hFFFF);
        wb_read(ADR_NONE, rd); check_reg("unmapped", rd, 32'h00000000);
        // second reset clears the enables again
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        wb_read(ADR_PWR, rd); check_reg("power re-reset", rd, 32'h00000000);
        wb_read(ADR_LOCK, rd); check_reg("lock re-reset", rd, 32'h00000000);
        final_report();
    end

    // whole run is about 160 cycles; generous margin
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("wrong value at %0t: run did not finish", $time);
        final_report();
    end
endmodule : acg_clock_power_tb
`default_nettype wire
